// [rtl/cc_map.vh]
// register map, field positions, reset values and timing counts
`ifndef CC_MAP_VH
`define CC_MAP_VH
// word indexes (byte address = 4 * index)
`define CC_IDX_TCTL 10'h000
`define CC_IDX_TVAL 10'h004
`define CC_IDX_TREL 10'h008
`define CC_IDX_IST 10'h010
`define CC_IDX_ICLR 10'h011
`define CC_IDX_IEN 10'h012
`define CC_IDX_CMODE 10'h040
`define CC_IDX_CVAL 10'h080
// timer control fields
`define CC_TC_SEL 2:0
`define CC_TC_SRC 4:3
`define CC_TC_RUN 5
`define CC_TC_W 6
// timer clock sources
`define CC_SRC_PRE 2'h0
`define CC_SRC_OVF 2'h1
`define CC_SRC_PIN 2'h2
// channel config fields
`define CC_CM_MODE 2:0
`define CC_CM_TMR 3
`define CC_CM_DBL 4
`define CC_CM_W 5
// channel modes
`define CC_M_OFF 3'h0
`define CC_M_CAPR 3'h1
`define CC_M_CAPF 3'h2
`define CC_M_CAPB 3'h3
`define CC_M_CMP0 3'h4
`define CC_M_CMP1 3'h5
`define CC_M_CMP2 3'h6
`define CC_M_CMP3 3'h7
// prescaler: division 8 << sel
`define CC_PRE_BASE 10'h008
`define CC_TMR_MAX 16'hFFFF
// reset values
`define CC_RST_TCTL 6'h00
`define CC_RST_CMODE 5'h00
`define CC_RST_W16 16'h0000
`define CC_RST_W32 32'h00000000
`define CC_RST_OE 32'hFFFFFFFF
// bus answers
`define CC_RESP_OK 2'h0
`define CC_RESP_ERR 2'h2
`endif

// [rtl/cc_pin_sync.v]
// three-stage pin synchroniser with edge pulses
module cc_pin_sync (
  input wire aclk,
  input wire aresetn,
  input wire din,
  output reg level_r,
  output reg rise_r,
  output reg fall_r
);
  reg q1_r;
  reg q2_r;
  reg q3_r;

  // chain; level changes once stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      q1_r <= 1'b0;
      q2_r <= 1'b0;
      q3_r <= 1'b0;
      level_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      q1_r <= din;
      q2_r <= q1_r;
      q3_r <= q2_r;
      rise_r <= (q2_r == q3_r) && q3_r && !level_r;
      fall_r <= (q2_r == q3_r) && !q3_r && level_r;
      if (q2_r == q3_r) begin
        level_r <= q3_r;
      end
    end
  end
endmodule // cc_pin_sync

// [rtl/cc_timer.v]
// 16-bit up timer with reload register and clock source select
`include "cc_map.vh"
module cc_timer (
  input wire aclk,
  input wire aresetn,
  input wire [2:0] sel,
  input wire [1:0] src,
  input wire run,
  input wire ovf_in,
  input wire cnt_in,
  input wire wr_val,
  input wire wr_rel,
  input wire [15:0] wdata,
  output reg [15:0] val_r,
  output reg [15:0] rel_r,
  output reg step_r,
  output reg ovf_r
);
  reg [9:0] div_r;
  wire [9:0] mask;
  wire tick;

  assign mask = (`CC_PRE_BASE << sel) - 10'h001;
  assign tick = run && (((src == `CC_SRC_PRE) && ((div_r & mask) == mask)) ||
                        ((src == `CC_SRC_OVF) && ovf_in) ||
                        ((src == `CC_SRC_PIN) && cnt_in));

  // free-running prescaler divider
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 10'h000;
    end else begin
      div_r <= div_r + 10'h001;
    end
  end

  // count, reload on overflow; software write wins over a tick
  always @(posedge aclk) begin
    if (!aresetn) begin
      val_r <= `CC_RST_W16;
      rel_r <= `CC_RST_W16;
      step_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      step_r <= 1'b0;
      ovf_r <= 1'b0;
      if (wr_rel) begin
        rel_r <= wdata;
      end
      if (wr_val) begin
        val_r <= wdata;
      end else if (tick) begin
        step_r <= 1'b1;
        if (val_r == `CC_TMR_MAX) begin
          val_r <= rel_r;
          ovf_r <= 1'b1;
        end else begin
          val_r <= val_r + 16'h0001;
        end
      end
    end
  end
endmodule // cc_timer

// [rtl/cc_array_top.v]
// dual capture/compare unit array with AXI4-Lite register slave
//
// Behaviour
// - two independent units of sixteen channels, thirty-two channels total
// - each unit holds two 16-bit timers, each with a reload register
// - timer clock is the prescaled system clock or the external overflow tick
// - first timer of each unit can also count an external count pin
// - every channel picks its unit timer and capture or compare function
// - each channel owns one pin: capture input or compare output
// - capture copies the allocated timer value into the channel register
// - every capture sets that channel's interrupt flag
// - capture trigger is rising, falling or both edges
// - compare channels match against their timer on each timer step, then act
// - mode 0 only raises interrupts, several per period, pin untouched
// - mode 1 toggles the pin on every match
// - mode 2 raises at most one interrupt per timer period
// - mode 3 sets pin on match, clears on overflow, once per period
// - double register mode: two registers toggle one shared pin
// - 3-bit select divides the clock by 8 up to 1024
// - period follows reload; reload zero gives full 16-bit period
`include "cc_map.vh"
module cc_array_top (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] cc_pin_in,
  output wire [31:0] cc_pin_out,
  output wire [31:0] cc_pin_oe_n,
  input wire [1:0] count_pin_in,
  input wire ovf_tick_in,
  output reg irq
);
  // byte-enable merge of a write into an old word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[8*b +: 8] = nw[8*b +: 8];
        end
      end
    end
  endfunction

  // true when a word index hits a mapped register
  function map_ok;
    input [9:0] idx;
    begin
      map_ok = (idx < 10'h00C) || (idx >= `CC_IDX_IST && idx <= `CC_IDX_IEN) ||
               (idx >= `CC_IDX_CMODE && idx < `CC_IDX_CMODE + 10'h020) ||
               (idx >= `CC_IDX_CVAL && idx < `CC_IDX_CVAL + 10'h020);
    end
  endfunction

  wire [9:0] w_idx;
  wire [9:0] r_idx;
  wire wr_en;
  wire rd_en;
  reg [31:0] rd_word;
  wire [`CC_TC_W*4-1:0] tctl_flat;
  reg [31:0] ist_r;
  reg [31:0] ien_r;
  wire [31:0] ist_nxt;
  wire [31:0] ev;
  wire [31:0] iclr;
  wire [63:0] tmr_val;
  wire [63:0] tmr_rel;
  wire [3:0] tmr_step;
  wire [3:0] tmr_ovf;
  wire [1:0] cnt_rise;
  wire [159:0] cfg_flat;
  wire [511:0] val_flat;
  wire [31:0] dbl_act;
  wire [31:0] dbl_tog;
  reg [31:0] pin_r;
  reg [31:0] oe_n_r;
  wire [31:0] pin_nxt;
  wire [31:0] oe_n_nxt;

  assign w_idx = s_axi_awaddr[11:2];
  assign r_idx = s_axi_araddr[11:2];
  assign wr_en = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_en = s_axi_arvalid && s_axi_arready;
  assign cc_pin_out = pin_r;
  assign cc_pin_oe_n = oe_n_r;

  // write channel: take address and data together, answer after
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CC_RESP_OK;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= map_ok(w_idx) ? `CC_RESP_OK : `CC_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel: one cycle ready, data the cycle after
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `CC_RST_W32;
      s_axi_rresp <= `CC_RESP_OK;
    end else begin
      s_axi_arready <= 1'b0;
      if (rd_en) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= map_ok(r_idx) ? `CC_RESP_OK : `CC_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // read decode; unmapped and write-only words read zero
  always @* begin
    rd_word = `CC_RST_W32;
    if (r_idx < `CC_IDX_TVAL) begin
      rd_word[`CC_TC_W-1:0] = tctl_flat[r_idx[1:0]*`CC_TC_W +: `CC_TC_W];
    end else if (r_idx < `CC_IDX_TREL) begin
      rd_word[15:0] = tmr_val[r_idx[1:0]*16 +: 16];
    end else if (r_idx < 10'h00C) begin
      rd_word[15:0] = tmr_rel[r_idx[1:0]*16 +: 16];
    end else if (r_idx == `CC_IDX_IST) begin
      rd_word = ist_r;
    end else if (r_idx == `CC_IDX_IEN) begin
      rd_word = ien_r;
    end else if (r_idx >= `CC_IDX_CMODE && r_idx < `CC_IDX_CMODE + 10'h020) begin
      rd_word[`CC_CM_W-1:0] = cfg_flat[r_idx[4:0]*`CC_CM_W +: `CC_CM_W];
    end else if (r_idx >= `CC_IDX_CVAL && r_idx < `CC_IDX_CVAL + 10'h020) begin
      rd_word[15:0] = val_flat[r_idx[4:0]*16 +: 16];
    end
  end

  // interrupt status: set by events, cleared by write-one, set wins
  assign iclr = (wr_en && w_idx == `CC_IDX_ICLR) ? merge(`CC_RST_W32, s_axi_wdata, s_axi_wstrb) : `CC_RST_W32;
  assign ist_nxt = (ist_r & ~iclr) | ev;

  always @(posedge aclk) begin
    if (!aresetn) begin
      ist_r <= `CC_RST_W32;
      ien_r <= `CC_RST_W32;
      irq <= 1'b0;
    end else begin
      ist_r <= ist_nxt;
      if (wr_en && w_idx == `CC_IDX_IEN) begin
        ien_r <= merge(ien_r, s_axi_wdata, s_axi_wstrb);
      end
      irq <= |(ist_nxt & ien_r);
    end
  end

  // external count pins for the first timer of each unit
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : cnt
      cc_pin_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(count_pin_in[p]),
        .level_r(),
        .rise_r(cnt_rise[p]),
        .fall_r()
      );
    end
  endgenerate

  genvar t;
  generate
    for (t = 0; t < 4; t = t + 1) begin : tmr
      reg [`CC_TC_W-1:0] tc_r;
      wire [`CC_TC_W-1:0] tc;
      wire [1:0] src;
      wire [31:0] wd;
      assign tc = tc_r;
      assign tctl_flat[t*`CC_TC_W +: `CC_TC_W] = tc_r;
      assign wd = merge({16'h0000, tmr_val[t*16 +: 16]}, s_axi_wdata, s_axi_wstrb);
      // pin source only on first timer
      assign src = (t % 2 == 1 && tc[`CC_TC_SRC] == `CC_SRC_PIN) ? `CC_SRC_PRE : tc[`CC_TC_SRC];

      // timer control register
      always @(posedge aclk) begin
        if (!aresetn) begin
          tc_r <= `CC_RST_TCTL;
        end else if (wr_en && w_idx == `CC_IDX_TCTL + t) begin
          tc_r <= s_axi_wdata[`CC_TC_W-1:0];
        end
      end

      cc_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .sel(tc[`CC_TC_SEL]),
        .src(src),
        .run(tc[`CC_TC_RUN]),
        .ovf_in(ovf_tick_in),
        .cnt_in(cnt_rise[t/2]),
        .wr_val(wr_en && w_idx == `CC_IDX_TVAL + t),
        .wr_rel(wr_en && w_idx == `CC_IDX_TREL + t),
        .wdata(wd[15:0]),
        .val_r(tmr_val[t*16 +: 16]),
        .rel_r(tmr_rel[t*16 +: 16]),
        .step_r(tmr_step[t]),
        .ovf_r(tmr_ovf[t])
      );
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : ch
      reg [`CC_CM_W-1:0] cfg_r;
      reg [15:0] val_r;
      reg done_r;
      wire [2:0] mode;
      wire [1:0] ti;
      wire [15:0] tv;
      wire rise;
      wire fall;
      wire cap;
      wire match;
      wire fire;
      wire [31:0] wd;
      assign mode = cfg_r[`CC_CM_MODE];
      assign ti = {i / 16 == 1, cfg_r[`CC_CM_TMR]};
      assign tv = tmr_val[ti*16 +: 16];
      assign cfg_flat[i*`CC_CM_W +: `CC_CM_W] = cfg_r;
      assign val_flat[i*16 +: 16] = val_r;
      assign wd = merge({16'h0000, val_r}, s_axi_wdata, s_axi_wstrb);

      cc_pin_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(cc_pin_in[i]),
        .level_r(),
        .rise_r(rise),
        .fall_r(fall)
      );

      assign cap = ((mode == `CC_M_CAPR) && rise) || ((mode == `CC_M_CAPF) && fall) ||
                   ((mode == `CC_M_CAPB) && (rise || fall));
      assign match = mode[2] && tmr_step[ti] && (tv == val_r);
      // once per period
      // a match in the overflow cycle already belongs to the new period
      assign fire = match && (!mode[1] || !done_r || tmr_ovf[ti]);
      assign ev[i] = cap || fire;

      // config and value registers; software write wins over capture
      always @(posedge aclk) begin
        if (!aresetn) begin
          cfg_r <= `CC_RST_CMODE;
          val_r <= `CC_RST_W16;
          done_r <= 1'b0;
        end else begin
          if (wr_en && w_idx == `CC_IDX_CMODE + i) begin
            cfg_r <= s_axi_wdata[`CC_CM_W-1:0];
          end
          if (wr_en && w_idx == `CC_IDX_CVAL + i) begin
            val_r <= wd[15:0];
          end else if (cap) begin
            val_r <= tv;
          end
          if (fire) begin
            done_r <= 1'b1;
          end else if (tmr_ovf[ti]) begin
            done_r <= 1'b0;
          end
        end
      end

      // upper channel drives its lower partner pin
      if (i % 16 >= 8) begin : up
        assign dbl_act[i] = cfg_r[`CC_CM_DBL] && (mode == `CC_M_CMP1);
        assign dbl_tog[i] = dbl_act[i] && fire;
        assign pin_nxt[i] = (mode == `CC_M_CMP1 && !dbl_act[i] && fire) ? !pin_r[i] :
                            (mode == `CC_M_CMP3 && tmr_ovf[ti]) ? 1'b0 :
                            (mode == `CC_M_CMP3 && fire) ? 1'b1 : pin_r[i];
        assign oe_n_nxt[i] = !((mode == `CC_M_CMP1 && !dbl_act[i]) || mode == `CC_M_CMP3);
      end else begin : lo
        wire tog;
        assign dbl_act[i] = 1'b0;
        assign dbl_tog[i] = 1'b0;
        // toggle on own or partner match
        assign tog = ((mode == `CC_M_CMP1) && fire) ^ dbl_tog[i+8];
        // set on match, clear on overflow
        assign pin_nxt[i] = (mode == `CC_M_CMP3 && tmr_ovf[ti]) ? 1'b0 :
                            (mode == `CC_M_CMP3 && fire) ? 1'b1 : (pin_r[i] ^ tog);
        assign oe_n_nxt[i] = !(mode == `CC_M_CMP1 || mode == `CC_M_CMP3 || dbl_act[i+8]);
      end
    end
  endgenerate

  // pin output and enable registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_r <= `CC_RST_W32;
      oe_n_r <= `CC_RST_OE;
    end else begin
      pin_r <= pin_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end
endmodule // cc_array_top

// [sim/cc_array_asserts.sv]
// bus and pin timing checker for the capture/compare array
module cc_array_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] cc_pin_oe_n,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // handshake pulses and answer timing
  chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready longer than one cycle");
  chk_aw_pair: assert property (s_axi_awready == s_axi_wready) else $error("awready and wready differ");
  chk_b_follows: assert property (s_axi_awready |=> s_axi_bvalid) else $error("write answer late");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready longer than one cycle");
  chk_r_follows: assert property (s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  // pin direction only moves with a config write
  chk_pin_dir: assert property (!$stable(cc_pin_oe_n) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("pin direction changed without a write");
  // interrupt only drops after a write
  chk_irq_clear: assert property ($fell(irq) |-> $past(s_axi_wready) || $past(s_axi_wready, 2))
    else $error("irq dropped without a write");
endmodule // cc_array_asserts

bind cc_array_top cc_array_asserts cc_array_asserts_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .cc_pin_oe_n(cc_pin_oe_n), .irq(irq));

// [sim/cc_pin_model.sv]
// pin loads and external event sources beside the array
module cc_pin_model (
  input wire logic [31:0] ext_lvl,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe_n,
  input wire logic [1:0] cnt_lvl,
  input wire logic tick,
  output wire logic [31:0] pin_in,
  output wire logic [1:0] count_pin,
  output wire logic ovf_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  // shared pin level
  // driven pins read back the drive, released pins the outside source
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
  assign count_pin = cnt_lvl;
  assign ovf_tick = tick;
endmodule // cc_pin_model

// [sim/dual_capture_compare_array_tb_top.sv]
// self-checking bench for the capture/compare array
`include "cc_map.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
`define WAITC(c) begin k = 0; while (!(c) && k < 400) begin @(posedge aclk); k++; end if (!(c)) tmo(); end
module dual_capture_compare_array_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000, ext = 32'h00000000, rdata, pin_out, oe_n, pin_in, c, t;
  logic [1:0] bresp, rresp, rr, br, cnt = 2'h0, cpin;
  logic [3:0] strb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq, tick = 1'h0, otick;
  int failures = 0, compares = 0, k;
  // clock
  always #2.5 aclk = ~aclk;
  cc_array_top cc_array_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cc_pin_in(pin_in), .cc_pin_out(pin_out),
    .cc_pin_oe_n(oe_n), .count_pin_in(cpin), .ovf_tick_in(otick), .irq(irq));
  cc_pin_model cc_pin_model_i (.ext_lvl(ext), .pin_out(pin_out), .pin_oe_n(oe_n), .cnt_lvl(cnt), .tick(tick),
    .pin_in(pin_in), .count_pin(cpin), .ovf_tick(otick));
  task results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task tmo;
    failures++;
    $display("[FAIL] wait expired");
    results();
  endtask
  // bus write, valids together
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    `WAITC(awready === 1'h1)
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    `WAITC(bvalid === 1'h1)
    br = bresp;
    bready <= 1'h0;
  endtask
  // bus read
  task automatic rd(input logic [9:0] idx, output logic [31:0] d);
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    `WAITC(arready === 1'h1)
    arvalid <= 1'h0;
    `WAITC(rvalid === 1'h1)
    d = rdata;
    rr = rresp;
    rready <= 1'h0;
  endtask
  task t_reset;
    rd(`CC_IDX_TCTL, c);
    `CHK("tctl0 reset", 32'h00000000, c)
    rd(10'h3FF, c);
    `CHK("unmapped resp", `CC_RESP_ERR, rr)
    `CHK("unmapped data", 32'h00000000, c)
    wr(10'h3FF, 32'h00000000);
    `CHK("unmapped bresp", `CC_RESP_ERR, br)
  endtask
  // capture on rise, ignore fall, then falling-edge mode
  task t_capture;
    wr(`CC_IDX_TCTL, 32'h00000020);
    wr(`CC_IDX_IEN, 32'h00000001);
    wr(`CC_IDX_CMODE, {29'h0, `CC_M_CAPR});
    @(posedge aclk) ext[0] <= 1'h1;
    `WAITC(irq === 1'h1)
    rd(`CC_IDX_CVAL, c);
    rd(`CC_IDX_TVAL, t);
    `CHK("capture value", 1'h1, (t[15:0] - c[15:0]) <= 16'h0002)
    wr(`CC_IDX_ICLR, 32'h00000001);
    `CHK("irq cleared", 1'h0, irq)
    @(posedge aclk) ext[0] <= 1'h0;
    repeat (10) @(posedge aclk);
    `CHK("fall ignored", 1'h0, irq)
    wr(`CC_IDX_CMODE, {29'h0, `CC_M_CAPF});
    @(posedge aclk) ext[0] <= 1'h1;
    repeat (10) @(posedge aclk);
    `CHK("rise ignored", 1'h0, irq)
    @(posedge aclk) ext[0] <= 1'h0;
    `WAITC(irq === 1'h1)
    wr(`CC_IDX_CMODE, {29'h0, `CC_M_CAPB});
    wr(`CC_IDX_ICLR, 32'h00000001);
    @(posedge aclk) ext[0] <= 1'h1;
    repeat (10) @(posedge aclk);
    `CHK("both rise", 1'h1, irq)
    wr(`CC_IDX_ICLR, 32'h00000001);
    @(posedge aclk) ext[0] <= 1'h0;
    repeat (10) @(posedge aclk);
    `CHK("both fall", 1'h1, irq)
    wr(`CC_IDX_CMODE, {29'h0, `CC_M_OFF});
    wr(`CC_IDX_ICLR, 32'h00000001);
  endtask
  // mode 1 toggles pin, flag set, masked irq stays low
  task t_toggle;
    rd(`CC_IDX_TVAL, t);
    wr(`CC_IDX_CVAL + 10'h001, t + 32'h00000008);
    wr(`CC_IDX_CMODE + 10'h001, {29'h0, `CC_M_CMP1});
    @(posedge aclk);
    `CHK("cmp1 drives", 1'h0, oe_n[1])
    `WAITC(pin_out[1] === 1'h1)
    rd(`CC_IDX_IST, c);
    `CHK("cmp1 flag", 1'h1, c[1])
    `CHK("masked irq", 1'h0, irq)
  endtask
  task tk;
    @(posedge aclk) tick <= 1'h1;
    @(posedge aclk) tick <= 1'h0;
    repeat (4) @(posedge aclk);
  endtask
  // mode 3 on second timer from overflow ticks
  task t_mode3;
    wr(`CC_IDX_TVAL + 10'h001, 32'h0000FFFD);
    wr(`CC_IDX_TREL + 10'h001, 32'h0000FFFD);
    wr(`CC_IDX_CVAL + 10'h002, 32'h0000FFFE);
    wr(`CC_IDX_CMODE + 10'h002, {28'h0, 1'h1, `CC_M_CMP3});
    wr(`CC_IDX_TCTL + 10'h001, 32'h00000028);
    tk();
    `CHK("m3 set", 1'h1, pin_out[2])
    tk();
    `CHK("m3 hold", 1'h1, pin_out[2])
    tk();
    `CHK("m3 clear", 1'h0, pin_out[2])
    rd(`CC_IDX_TVAL + 10'h001, c);
    `CHK("reload", 32'h0000FFFD, c)
    rd(`CC_IDX_IST, c);
    `CHK("m3 flag", 1'h1, c[2])
  endtask
  // modes 0 and 2, byte strobes and double mode on unit B second timer
  task t_modes;
    wr(`CC_IDX_TVAL + 10'h003, 32'h0000FFFC);
    wr(`CC_IDX_TREL + 10'h003, 32'h0000FFFC);
    wr(`CC_IDX_CVAL + 10'h010, 32'h0000FFFD);
    wr(`CC_IDX_CVAL + 10'h011, 32'h0000FFFF);
    @(posedge aclk) strb <= 4'h1;
    wr(`CC_IDX_CVAL + 10'h011, 32'h0000AAFD);
    strb <= 4'hF;
    rd(`CC_IDX_CVAL + 10'h011, c);
    `CHK("byte strobe", 32'h0000FFFD, c)
    wr(`CC_IDX_CVAL + 10'h01A, 32'h0000FFFE);
    wr(`CC_IDX_CMODE + 10'h010, {27'h0, 2'h1, `CC_M_CMP0});
    wr(`CC_IDX_CMODE + 10'h011, {27'h0, 2'h1, `CC_M_CMP2});
    wr(`CC_IDX_CMODE + 10'h01A, {27'h0, 2'h3, `CC_M_CMP1});
    wr(`CC_IDX_TCTL + 10'h003, 32'h00000028);
    `CHK("pin directions", 32'h04030000, oe_n & 32'h04070000)
    tk();
    rd(`CC_IDX_IST, c);
    `CHK("first match", 2'h3, c[17:16])
    wr(`CC_IDX_ICLR, 32'h00030000);
    wr(`CC_IDX_TVAL + 10'h003, 32'h0000FFFC);
    tk();
    rd(`CC_IDX_IST, c);
    `CHK("same period", 2'h1, c[17:16])
    `CHK("mode0 pin", 1'h0, pin_out[16])
    tk();
    `CHK("double toggle", 1'h1, pin_out[18])
    rd(`CC_IDX_IST, c);
    `CHK("double flag", 1'h1, c[26])
    tk();
    tk();
    tk();
    rd(`CC_IDX_IST, c);
    `CHK("next period", 1'h1, c[17])
  endtask
  // external count pin on unit B first timer
  task t_count;
    wr(`CC_IDX_TCTL + 10'h002, 32'h00000030);
    repeat (3) begin
      @(posedge aclk) cnt[1] <= 1'h1;
      repeat (4) @(posedge aclk);
      cnt[1] <= 1'h0;
      repeat (4) @(posedge aclk);
    end
    repeat (8) @(posedge aclk);
    rd(`CC_IDX_TVAL + 10'h002, c);
    `CHK("count pin", 32'h00000003, c)
    wr(`CC_IDX_TCTL + 10'h001, 32'h00000021);
    wr(`CC_IDX_TVAL + 10'h001, 32'h00000000);
    repeat (160) @(posedge aclk);
    rd(`CC_IDX_TVAL + 10'h001, c);
    `CHK("divide 16", 1'h1, c >= 32'h0000000A && c <= 32'h0000000B)
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_capture();
    t_toggle();
    t_mode3();
    t_modes();
    t_count();
    results();
  end
endmodule // dual_capture_compare_array_tb_top
